// File: rtl/irq_wake_pkg.sv
//==============================================================================
package irq_wake_pkg;

  //============================================================================
  // Widths and register offsets.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PC_W   = 12;

  localparam logic [ADDR_W-1:0] OFF_CTRL      = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_TMR_FLAG  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_TMR_EN    = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_SH_EN     = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_SH_FLAG   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_AUX_FLAG  = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT  = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK  = 4'h7;

  //============================================================================
  // Field positions.
  localparam int unsigned CTRL_GIE_BIT   = 0;
  localparam int unsigned CTRL_SERV_BIT  = 1;
  localparam int unsigned EVT_WAKE_BIT   = 0;
  localparam int unsigned EVT_CALL_BIT   = 1;
  localparam int unsigned EVT_BLOCK_BIT  = 2;
  localparam int unsigned AUX_PIN_BIT    = 0;
  localparam int unsigned AUX_LVD_BIT    = 1;
  localparam int unsigned AUX_CMP_BIT    = 2;
  localparam int unsigned AUX_W          = 3;

  //============================================================================
  // Vector layout and reset values.
  localparam logic [PC_W-1:0]   VEC_BASE  = 12'h00C;
  localparam logic [PC_W-1:0]   VEC_STEP  = 12'h004;
  localparam logic [DATA_W-1:0] BYTE_RST  = 8'h00;
  localparam logic              GIE_RST   = 1'b0;

  //============================================================================
  // Types.
  typedef enum logic [1:0] {
    ST_READY   = 2'b00,
    ST_ENTER   = 2'b01,
    ST_SERVICE = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic            stack_full;
    logic            sleep;
    logic            ret;
    logic            return_and_reenable_instr;
    logic [PC_W-1:0] pc;
  } cpu_req_t;

  typedef struct packed {
    logic            call;
    logic [PC_W-1:0] vector;
    logic            push;
    logic [PC_W-1:0] push_pc;
    logic            pop;
  } cpu_cmd_t;

  typedef struct packed {
    seq_state_t        st;
    logic              global_en;
    logic [DATA_W-1:0] tflag;
    logic [DATA_W-1:0] ten;
    logic [DATA_W-1:0] sh_en;
    logic [DATA_W-1:0] sh_flag;
    logic [DATA_W-1:0] aux_flag;
    logic [DATA_W-1:0] evt_st;
    logic [DATA_W-1:0] evt_mask;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              wake;
    cpu_cmd_t          cmd;
  } state_t;

  //============================================================================
  // Index of the lowest set bit; lowest shared interrupt has the highest priority.
  function automatic logic [2:0] first_set(input logic [DATA_W-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_set

  // Vector address of a shared interrupt.
  function automatic logic [PC_W-1:0] vec_addr(input logic [2:0] idx);
    return PC_W'(VEC_BASE + PC_W'(VEC_STEP * PC_W'(idx)));
  endfunction : vec_addr

endpackage : irq_wake_pkg

// File: rtl/timer_interrupt_wakeup_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module timer_interrupt_wakeup_ctrl #(
  parameter int unsigned NUM_TIMERS = 3,
  parameter int unsigned NUM_SHARED = 2
) (
  // Clock and reset.
  input  wire logic                               clk_sys_i,
  input  wire logic                               rst_i,
  // Register port.
  input  wire irq_wake_pkg::bus_req_t             bus_i,
  output logic [irq_wake_pkg::DATA_W-1:0]         rdata_o,
  // Timer comparator match pulses.
  input  wire logic [NUM_TIMERS-1:0]              timer_p_match_i,
  input  wire logic [NUM_TIMERS-1:0]              timer_a_match_i,
  // Pin edge, low supply and comparator change pulses.
  input  wire logic [irq_wake_pkg::AUX_W-1:0]     aux_event_i,
  // Program sequencer and stack.
  input  wire irq_wake_pkg::cpu_req_t             cpu_i,
  output irq_wake_pkg::cpu_cmd_t                  cpu_cmd_o,
  output logic                                    wake_o,
  output logic                                    global_irq_enable_o,
  output logic                                    in_service_o,
  // Event interrupt.
  output logic                                    irq_o
);

  //============================================================================
  // Masks of implemented bits.
  localparam logic [irq_wake_pkg::DATA_W-1:0] TFLAG_MASK =
    8'((16'h0001 << (2 * NUM_TIMERS)) - 16'h0001);
  localparam logic [irq_wake_pkg::DATA_W-1:0] SH_MASK =
    8'((16'h0001 << NUM_SHARED) - 16'h0001);
  localparam logic [irq_wake_pkg::DATA_W-1:0] AUX_MASK = 8'h07;
  localparam logic [irq_wake_pkg::DATA_W-1:0] EVT_MASK_BITS = 8'h07;

  localparam irq_wake_pkg::state_t STATE_RST = '{
    st:        irq_wake_pkg::ST_READY,
    global_en: irq_wake_pkg::GIE_RST,
    tflag:     irq_wake_pkg::BYTE_RST,
    ten:       irq_wake_pkg::BYTE_RST,
    sh_en:     irq_wake_pkg::BYTE_RST,
    sh_flag:   irq_wake_pkg::BYTE_RST,
    aux_flag:  irq_wake_pkg::BYTE_RST,
    evt_st:    irq_wake_pkg::BYTE_RST,
    evt_mask:  irq_wake_pkg::BYTE_RST,
    rdata:     irq_wake_pkg::BYTE_RST,
    irq:       1'b0,
    wake:      1'b0,
    cmd:       '0
  };

  // Shared interrupt that a timer module feeds.
  function automatic int unsigned group_of(input int unsigned t);
    return t % NUM_SHARED;
  endfunction : group_of

  irq_wake_pkg::state_t state_reg;
  irq_wake_pkg::state_t state_next;

  // All request flags side by side, for wake-up edge detection.
  logic [3*irq_wake_pkg::DATA_W-1:0] flag_vec;

  assign flag_vec = {state_reg.aux_flag, state_reg.sh_flag, state_reg.tflag};

  //============================================================================
  // Next-state logic.
  always_comb begin
    logic [irq_wake_pkg::DATA_W-1:0]   tset;
    logic [irq_wake_pkg::DATA_W-1:0]   shset;
    logic [irq_wake_pkg::DATA_W-1:0]   auxset;
    logic [irq_wake_pkg::DATA_W-1:0]   pend;
    logic [irq_wake_pkg::DATA_W-1:0]   onehot;
    logic [2:0]                        idx;
    logic [3*irq_wake_pkg::DATA_W-1:0] rise;
    logic                              ret_any;
    tset       = '0;
    shset      = '0;
    auxset     = '0;
    pend       = '0;
    onehot     = '0;
    idx        = 3'h0;
    rise       = '0;
    ret_any    = cpu_i.ret | cpu_i.return_and_reenable_instr;
    state_next = state_reg;
    state_next.cmd.call = 1'b0;
    state_next.cmd.push = 1'b0;
    state_next.cmd.pop  = 1'b0;
    state_next.wake     = 1'b0;
    state_next.rdata    = '0;

    // A match sets its own flag always; it reaches the shared flag only when enabled.
    for (int i = 0; i < NUM_TIMERS; i++) begin
      tset[2*i]   = timer_p_match_i[i];
      tset[2*i+1] = timer_a_match_i[i];
      if ((timer_p_match_i[i] && state_reg.ten[2*i]) ||
          (timer_a_match_i[i] && state_reg.ten[2*i+1])) begin
        shset[group_of(i)] = 1'b1;
      end
    end
    // The auxiliary sources set their flags with no enable at all.
    auxset = {5'h00, aux_event_i} & AUX_MASK;

    // Software writes; request flags take any value, including high; event status bits only clear where a one is written.
    if (bus_i.wr) begin
      case (bus_i.addr)
        irq_wake_pkg::OFF_CTRL: begin
          state_next.global_en = bus_i.wdata[irq_wake_pkg::CTRL_GIE_BIT];
        end
        irq_wake_pkg::OFF_TMR_FLAG: begin
          state_next.tflag = bus_i.wdata & TFLAG_MASK;
        end
        irq_wake_pkg::OFF_TMR_EN: begin
          state_next.ten = bus_i.wdata & TFLAG_MASK;
        end
        irq_wake_pkg::OFF_SH_EN: begin
          state_next.sh_en = bus_i.wdata & SH_MASK;
        end
        irq_wake_pkg::OFF_SH_FLAG: begin
          state_next.sh_flag = bus_i.wdata & SH_MASK;
        end
        irq_wake_pkg::OFF_AUX_FLAG: begin
          state_next.aux_flag = bus_i.wdata & AUX_MASK;
        end
        irq_wake_pkg::OFF_EVT_STAT: begin
          state_next.evt_st = state_reg.evt_st & ~bus_i.wdata;
        end
        irq_wake_pkg::OFF_EVT_MASK: begin
          state_next.evt_mask = bus_i.wdata & EVT_MASK_BITS;
        end
        default: begin
        end
      endcase
    end

    // Hardware sets come after the write, so a set in the clearing cycle wins.
    state_next.tflag    = state_next.tflag | tset;
    state_next.sh_flag  = state_next.sh_flag | shset;
    state_next.aux_flag = state_next.aux_flag | auxset;

    // Returns pop the address; only the re-enabling one touches global enable.
    if (ret_any) begin
      state_next.cmd.pop = 1'b1;
      if (cpu_i.return_and_reenable_instr) begin
        state_next.global_en = 1'b1;
      end
    end

    // Entry is held off while asleep, during a return and right after a call,
    // so the sequencer never sees two stack operations in one cycle.
    pend = state_reg.sh_flag & state_reg.sh_en & SH_MASK;
    if (state_reg.global_en && (pend != '0) && !ret_any && !cpu_i.sleep &&
        (state_reg.st != irq_wake_pkg::ST_ENTER)) begin
      if (cpu_i.stack_full) begin
        state_next.evt_st[irq_wake_pkg::EVT_BLOCK_BIT] = 1'b1;
      end else begin
        idx    = irq_wake_pkg::first_set(pend);
        onehot = 8'(8'h01 << idx);
        state_next.cmd.call    = 1'b1;
        state_next.cmd.vector  = irq_wake_pkg::vec_addr(idx);
        state_next.cmd.push    = 1'b1;
        state_next.cmd.push_pc = cpu_i.pc;
        state_next.global_en   = 1'b0;
        // Only the shared flag drops; timer flags stay for software.
        state_next.sh_flag = (state_next.sh_flag & ~onehot) | shset;
        state_next.evt_st[irq_wake_pkg::EVT_CALL_BIT] = 1'b1;
        state_next.st = irq_wake_pkg::ST_ENTER;
      end
    end else begin
      case (state_reg.st)
        irq_wake_pkg::ST_READY: begin
          state_next.st = irq_wake_pkg::ST_READY;
        end
        irq_wake_pkg::ST_ENTER: begin
          state_next.st = irq_wake_pkg::ST_SERVICE;
        end
        irq_wake_pkg::ST_SERVICE: begin
          if (ret_any) begin
            state_next.st = irq_wake_pkg::ST_READY;
          end
        end
        default: begin
          state_next.st = irq_wake_pkg::ST_READY;
        end
      endcase
    end

    // Wake on any low-to-high flag change; a flag already high cannot rise.
    rise = {state_next.aux_flag, state_next.sh_flag, state_next.tflag} & ~flag_vec;
    if (cpu_i.sleep && (rise != '0)) begin
      state_next.wake = 1'b1;
      state_next.evt_st[irq_wake_pkg::EVT_WAKE_BIT] = 1'b1;
    end

    // Read data stand only in the cycle after the strobe.
    if (bus_i.rd) begin
      case (bus_i.addr)
        irq_wake_pkg::OFF_CTRL: begin
          state_next.rdata[irq_wake_pkg::CTRL_GIE_BIT]  = state_reg.global_en;
          state_next.rdata[irq_wake_pkg::CTRL_SERV_BIT] =
            (state_reg.st == irq_wake_pkg::ST_SERVICE);
        end
        irq_wake_pkg::OFF_TMR_FLAG: state_next.rdata = state_reg.tflag;
        irq_wake_pkg::OFF_TMR_EN:   state_next.rdata = state_reg.ten;
        irq_wake_pkg::OFF_SH_EN:    state_next.rdata = state_reg.sh_en;
        irq_wake_pkg::OFF_SH_FLAG:  state_next.rdata = state_reg.sh_flag;
        irq_wake_pkg::OFF_AUX_FLAG: state_next.rdata = state_reg.aux_flag;
        irq_wake_pkg::OFF_EVT_STAT: state_next.rdata = state_reg.evt_st;
        irq_wake_pkg::OFF_EVT_MASK: state_next.rdata = state_reg.evt_mask;
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end

    state_next.irq = (state_next.evt_st & state_next.evt_mask) != '0;
  end

  //============================================================================
  // State register.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  //============================================================================
  // Outputs come straight from the state register.
  assign rdata_o             = state_reg.rdata;
  assign cpu_cmd_o           = state_reg.cmd;
  assign wake_o              = state_reg.wake;
  assign global_irq_enable_o = state_reg.global_en;
  // Only the service state code has its upper bit set, so the flag is a bare flip-flop bit.
  assign in_service_o        = state_reg.st[1];
  assign irq_o               = state_reg.irq;

  //============================================================================
  // Checks.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  call_needs_enable_a: assert property (
    state_reg.cmd.call |-> $past(state_reg.global_en) && !$past(cpu_i.stack_full) &&
      !$past(cpu_i.sleep))
    else $error("Vector call taken without global enable or with stack full.");

  call_clears_gie_a: assert property (
    state_reg.cmd.call |-> !state_reg.global_en ##1 state_reg.st == irq_wake_pkg::ST_SERVICE)
    else $error("Call did not clear global enable or enter service.");

  source_flag_kept_a: assert property (
    state_reg.cmd.call && !$past(bus_i.wr) |->
      (state_reg.tflag & $past(state_reg.tflag)) == $past(state_reg.tflag))
    else $error("Timer source flag cleared by servicing.");

  match_sets_flag_a: assert property (
    timer_a_match_i[0] |=> state_reg.tflag[1])
    else $error("Compare A match did not set its flag.");

  return_and_reenable_instr_sets_gie_a: assert property (
    cpu_i.return_and_reenable_instr |=> state_reg.global_en && state_reg.cmd.pop && !state_reg.cmd.call)
    else $error("Return-and-reenable did not pop and set global enable.");

  ret_keeps_gie_a: assert property (
    cpu_i.ret && !state_reg.global_en && !bus_i.wr |=> state_reg.cmd.pop ##0
      !state_reg.global_en [*2])
    else $error("Plain return changed global enable.");

  wake_on_rise_a: assert property (
    cpu_i.sleep && timer_p_match_i[0] && !state_reg.tflag[0] |=> state_reg.wake)
    else $error("Rising flag during sleep gave no wake-up.");

  wake_needs_rise_a: assert property (
    state_reg.wake |-> $past(cpu_i.sleep) && ((flag_vec & ~$past(flag_vec)) != '0))
    else $error("Wake-up without a rising request flag.");

  aux_wake_a: assert property (
    cpu_i.sleep && aux_event_i[irq_wake_pkg::AUX_PIN_BIT] &&
      !state_reg.aux_flag[irq_wake_pkg::AUX_PIN_BIT] |=>
      state_reg.wake && state_reg.aux_flag[irq_wake_pkg::AUX_PIN_BIT])
    else $error("Pin edge did not set its flag and wake.");

  push_pc_a: assert property (
    state_reg.cmd.call |-> state_reg.cmd.push && state_reg.cmd.push_pc == $past(cpu_i.pc))
    else $error("Entry did not push the program counter.");

  vector_call_a: assert property (
    state_reg.global_en && state_reg.sh_flag[0] && state_reg.sh_en[0] && !cpu_i.stack_full &&
      !cpu_i.sleep && !cpu_i.ret && !cpu_i.return_and_reenable_instr && state_reg.st != irq_wake_pkg::ST_ENTER |=>
      state_reg.cmd.call && state_reg.cmd.vector == irq_wake_pkg::VEC_BASE)
    else $error("Pending shared interrupt zero not vectored.");

  gie_gates_call_a: assert property (
    !state_reg.global_en |=> !state_reg.cmd.call)
    else $error("Vector call taken while global enable was clear.");

  shared_from_timer_a: assert property (
    timer_p_match_i[1] && state_reg.ten[2] |=> state_reg.sh_flag[group_of(1)])
    else $error("Enabled period match did not raise its shared flag.");

  blocked_when_full_a: assert property (
    state_reg.global_en && ((state_reg.sh_flag & state_reg.sh_en) != '0) &&
      cpu_i.stack_full && !cpu_i.sleep && !cpu_i.ret && !cpu_i.return_and_reenable_instr &&
      state_reg.st != irq_wake_pkg::ST_ENTER |=>
      !state_reg.cmd.call && state_reg.evt_st[irq_wake_pkg::EVT_BLOCK_BIT])
    else $error("Full stack did not hold off the call or flag the block.");

  sticky_timer_flag_a: assert property (
    state_reg.tflag[0] && !(bus_i.wr && bus_i.addr == irq_wake_pkg::OFF_TMR_FLAG) |=>
      state_reg.tflag[0])
    else $error("Timer source flag dropped without a software write.");

  software_set_a: assert property (
    bus_i.wr && bus_i.addr == irq_wake_pkg::OFF_TMR_FLAG && bus_i.wdata[0] |=>
      state_reg.tflag[0])
    else $error("Software could not set a timer request flag.");

  aux_sets_flag_a: assert property (
    aux_event_i[irq_wake_pkg::AUX_LVD_BIT] |=> state_reg.aux_flag[irq_wake_pkg::AUX_LVD_BIT])
    else $error("Low supply event did not set its flag.");

  wake_needs_sleep_a: assert property (
    !cpu_i.sleep |=> !state_reg.wake)
    else $error("Wake-up raised while the core was awake.");

  push_with_call_a: assert property (
    state_reg.cmd.push |-> state_reg.cmd.call && !state_reg.cmd.pop)
    else $error("Stack push outside a vector call.");

  period_sets_flag_a: assert property (
    timer_p_match_i[1] |=> state_reg.tflag[2])
    else $error("Period match did not set its flag.");

  ret_pops_a: assert property (
    cpu_i.ret |=> state_reg.cmd.pop && !state_reg.cmd.call)
    else $error("Plain return did not pop the return address.");

endmodule : timer_interrupt_wakeup_ctrl

`default_nettype wire

// File: test/cpu_seq_model.sv
`timescale 1ns/100ps
`default_nettype none

module cpu_seq_model #(
  parameter int unsigned DEPTH = 1
) (
  // Clock and reset.
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Commands from the controller and requests from the bench.
  input  wire irq_wake_pkg::cpu_cmd_t  cmd_i,
  input  wire logic                    sleep_i,
  input  wire logic                    ret_i,
  input  wire logic                    return_and_reenable_instr_i,
  // Core status towards the controller.
  output irq_wake_pkg::cpu_req_t       cpu_o,
  output logic [3:0]                   depth_o
);
  //============================================================================
  // Program counter and return stack.
  logic [11:0] stk [0:7];
  logic [11:0] pc_reg;
  logic [3:0]  sp_reg;

  // Only the return address goes on the stack; nothing else is saved.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sp_reg <= 4'h0;
      pc_reg <= 12'h100;
    end else if (cmd_i.call) begin
      if (cmd_i.push) begin
        stk[sp_reg[2:0]] <= cmd_i.push_pc;
      end
      sp_reg <= sp_reg + 4'h1;
      pc_reg <= cmd_i.vector;
    end else if (cmd_i.pop) begin
      sp_reg <= sp_reg - 4'h1;
      pc_reg <= stk[3'(sp_reg - 4'h1)];
    end else begin
      pc_reg <= pc_reg + 12'h001;
    end
  end

  // A full stack is reported as a level so the controller can hold off.
  assign cpu_o = '{stack_full: (sp_reg == 4'(DEPTH)), sleep: sleep_i, ret: ret_i,
                   return_and_reenable_instr: return_and_reenable_instr_i, pc: pc_reg};
  assign depth_o = sp_reg;
endmodule : cpu_seq_model

`default_nettype wire

// File: test/tb_timer_interrupt_wakeup_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module tb_timer_interrupt_wakeup_ctrl;
  //============================================================================
  // Signals.
  logic                   clk_sys_i, rst_i, sleep, ret, return_and_reenable_instr, wake_o, glob, in_srv, irq_o;
  irq_wake_pkg::bus_req_t bus;
  irq_wake_pkg::cpu_req_t cpu;
  irq_wake_pkg::cpu_cmd_t cpu_cmd;
  logic [7:0]             rdata_o;
  logic [2:0]             tp, ta, aux;
  logic [3:0]             depth;
  int                     n_mismatch, checks, n_call, n0;

  timer_interrupt_wakeup_ctrl u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus),
    .rdata_o(rdata_o), .timer_p_match_i(tp), .timer_a_match_i(ta), .aux_event_i(aux),
    .cpu_i(cpu), .cpu_cmd_o(cpu_cmd), .wake_o(wake_o), .global_irq_enable_o(glob),
    .in_service_o(in_srv), .irq_o(irq_o));
  cpu_seq_model #(.DEPTH(1)) u_cpu (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_i(cpu_cmd),
    .sleep_i(sleep), .ret_i(ret), .return_and_reenable_instr_i(return_and_reenable_instr), .cpu_o(cpu), .depth_o(depth));

  // Clock and a call counter used to prove that no call was made.
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) if (cpu_cmd.call === 1'b1) n_call++;

  //============================================================================
  // Comparison and bus tasks.
  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic chk_v(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_b(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_b
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    #1 chk_v({4'h0, rdata_o}, {4'h0, e});
  endtask : rd_chk
  // Kind 0 period match, 1 compare A match, 2 auxiliary event; one-cycle pulse.
  task automatic ev(input int kind, input int idx);
    @(posedge clk_sys_i);
    case (kind)
      0: tp[idx] <= 1'b1;
      1: ta[idx] <= 1'b1;
      default: aux[idx] <= 1'b1;
    endcase
    @(posedge clk_sys_i);
    {tp, ta, aux} <= 9'h000;
    #1;
  endtask : ev
  task automatic wait_call(input logic [11:0] vec);
    logic [11:0] p;
    int          k;
    #1;
    for (k = 0; k < 20; k++) begin
      p = cpu.pc;
      @(posedge clk_sys_i);
      #1;
      if (cpu_cmd.call === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      $display("BAD %0t no call", $time);
      give_verdict();
    end else begin
      chk_v(cpu_cmd.vector, vec);
      chk_v(cpu_cmd.push_pc, p);
      chk_b(cpu_cmd.push, 1'b1);
      chk_b(glob, 1'b0);
    end
  endtask : wait_call
  task automatic do_ret(input logic re, input logic exp_glob);
    @(posedge clk_sys_i);
    if (re) return_and_reenable_instr <= 1'b1;
    else ret <= 1'b1;
    @(posedge clk_sys_i);
    {ret, return_and_reenable_instr} <= 2'b00;
    #1 chk_b(cpu_cmd.pop, 1'b1);
    chk_b(glob, exp_glob);
  endtask : do_ret

  //============================================================================
  // Scenarios.
  task automatic t_reset_vals();
    for (int a = 0; a < 9; a++) rd_chk(4'(a), 8'h00);
  endtask : t_reset_vals
  task automatic t_flags();
    for (int i = 0; i < 3; i++) begin
      ev(0, i);
      ev(1, i);
    end
    rd_chk(irq_wake_pkg::OFF_TMR_FLAG, 8'h3F);
    wr(irq_wake_pkg::OFF_TMR_FLAG, 8'h00);
    rd_chk(irq_wake_pkg::OFF_TMR_FLAG, 8'h00);
  endtask : t_flags
  // Flag pends while the global enable is off, then vectors once it is set.
  task automatic t_vector();
    wr(irq_wake_pkg::OFF_TMR_EN, 8'h01);
    wr(irq_wake_pkg::OFF_SH_EN, 8'h01);
    ev(0, 0);
    rd_chk(irq_wake_pkg::OFF_SH_FLAG, 8'h01);
    chk_v(12'(n_call), 12'h000);
    wr(irq_wake_pkg::OFF_CTRL, 8'h01);
    wait_call(12'h00C);
    @(posedge clk_sys_i);
    #1 chk_v({8'h0, depth}, 12'h001);
    chk_b(in_srv, 1'b1);
    rd_chk(irq_wake_pkg::OFF_SH_FLAG, 8'h00);
    rd_chk(irq_wake_pkg::OFF_TMR_FLAG, 8'h01);
    wr(irq_wake_pkg::OFF_TMR_EN, 8'h00);
    rd_chk(irq_wake_pkg::OFF_TMR_FLAG, 8'h01);
  endtask : t_vector
  // A full stack blocks the call until a return frees a slot.
  task automatic t_full_return();
    wr(irq_wake_pkg::OFF_EVT_MASK, 8'h04);
    wr(irq_wake_pkg::OFF_TMR_EN, 8'h04);
    wr(irq_wake_pkg::OFF_SH_EN, 8'h03);
    wr(irq_wake_pkg::OFF_CTRL, 8'h01);
    n0 = n_call;
    ev(0, 1);
    repeat (3) @(posedge clk_sys_i);
    #1 chk_v(12'(n_call - n0), 12'h000);
    chk_b(irq_o, 1'b1);
    rd_chk(irq_wake_pkg::OFF_EVT_STAT, 8'h06);
    do_ret(1'b1, 1'b1);
    wait_call(12'h010);
    do_ret(1'b0, 1'b0);
    wr(irq_wake_pkg::OFF_EVT_STAT, 8'h07);
    rd_chk(irq_wake_pkg::OFF_EVT_STAT, 8'h00);
    chk_b(irq_o, 1'b0);
  endtask : t_full_return
  task automatic t_wake();
    wr(irq_wake_pkg::OFF_TMR_FLAG, 8'h00);
    wr(irq_wake_pkg::OFF_AUX_FLAG, 8'h00);
    @(posedge clk_sys_i);
    sleep <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      ev(2, k);
      chk_b(wake_o, 1'b1);
    end
    ev(2, 0);
    chk_b(wake_o, 1'b0);
    ev(1, 2);
    chk_b(wake_o, 1'b1);
    // A period match with its enable clear must still wake the core.
    ev(0, 0);
    chk_b(wake_o, 1'b1);
    wr(irq_wake_pkg::OFF_TMR_FLAG, 8'h20);
    chk_b(wake_o, 1'b0);
    wr(irq_wake_pkg::OFF_TMR_FLAG, 8'h21);
    chk_b(wake_o, 1'b1);
    wr(irq_wake_pkg::OFF_TMR_FLAG, 8'h21);
    chk_b(wake_o, 1'b0);
    @(posedge clk_sys_i);
    sleep <= 1'b0;
  endtask : t_wake

  //============================================================================
  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    {rst_i, sleep, ret, return_and_reenable_instr, tp, ta, aux} = 13'h1000;
    bus = '0;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_flags();
    t_vector();
    t_full_return();
    t_wake();
    give_verdict();
  end
endmodule : tb_timer_interrupt_wakeup_ctrl

`default_nettype wire
